// [rtl/mhup_device.sv]
// Purpose: modem end of the host serial ports, APB controlled
// Assumes: APB master, 50 MHz MCLK, host keeps its side
// Notes:   zero-wait slave, read data captured in setup
//
// Summary of operation
// - three serial ports with request/clear handshake
// - host leaves the spare port unused
// - debug port role switchable by software
// - port settings writable from reset defaults
// - modem receives on TXD, sends on RXD
// - host without handshake holds request low
// - command port 115200 8N1, handshake on
// - command request wakes, undriven rests high
// - command clear released during deep sleep
// - debug port debug role, 921600 8N1
// - debug request wakes the modem
// - console 115200 8N1, no handshake
// - console never wakes the modem
// - sleep decided inside the modem only
`timescale 1ns/1ps
`default_nettype none
module mhup_device (
  // Clock, reset, enable
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        CE,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Link
  mhup_link_if.dev         LINK,
  // Status to the core
  output logic             ASLEEP,
  output logic [5:0]       PORT_ROLE
);
  localparam int N = mhup_pkg::NPORT;
  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic reg_hit(input logic [7:0] a, input int p,
                                   input logic [7:0] ofs);
    reg_hit = a == (8'(p) * mhup_pkg::STRIDE + ofs);
  endfunction : reg_hit

  wire setup  = PSEL & ~PENABLE;
  wire access = PSEL & PENABLE;
  wire wr     = access & PWRITE;
  wire rd     = access & ~PWRITE;
  wire hit_pwr = PADDR == mhup_pkg::OFS_PWR;

  logic [N-1:0]  hit_any;
  logic [N-1:0]  tx_ready, rx_valid, rx_ovr, rx_ferr, req;
  logic [N-1:0]  flow_q, ovr_q, ferr_q;
  logic [15:0]   div_q  [N];
  logic [1:0]    role_q [N];
  logic [7:0]    rx_data [N];
  logic [31:0]   rd_port [N];
  logic          asleep_q, wake_seen_q;
  logic [31:0]   prdata_q;
  logic          pslverr_q;

  // ****************************************
  // Power state
  // ****************************************
  // command or debug request wakes
  wire wake = asleep_q & (req[0] | req[1]);
  wire sleep_wr = wr & hit_pwr & PWDATA[mhup_pkg::PWR_SLEEP];
  wire wake_clr = wr & hit_pwr & PWDATA[mhup_pkg::PWR_WAKE];
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      asleep_q    <= 1'b0;
      wake_seen_q <= 1'b0;
    end else if (CE) begin
      asleep_q    <= wake ? 1'b0 : (asleep_q | sleep_wr);
      wake_seen_q <= wake | (wake_seen_q & ~wake_clr);
    end
  end
  assign ASLEEP = asleep_q;

  // ****************************************
  // Ports
  // ****************************************
  for (genvar i = 0; i < N; i++) begin : g_port
    wire sel_ctrl = reg_hit(PADDR, i, mhup_pkg::OFS_CTRL);
    wire sel_txd  = reg_hit(PADDR, i, mhup_pkg::OFS_TXD);
    wire sel_rxd  = reg_hit(PADDR, i, mhup_pkg::OFS_RXD);
    wire sel_stat = reg_hit(PADDR, i, mhup_pkg::OFS_STAT);
    wire clr_ovr  = wr & sel_stat & PWDATA[mhup_pkg::ST_OVR];
    wire clr_ferr = wr & sel_stat & PWDATA[mhup_pkg::ST_FERR];
    // No new characters sent while asleep
    wire tx_push  = wr & sel_txd & ~asleep_q;
    wire rx_pop   = rd & sel_rxd;
    wire clear_n;
    assign hit_any[i] = sel_ctrl | sel_txd | sel_rxd | sel_stat;

    always_ff @(posedge MCLK) begin
      if (SRST) begin
        div_q[i]  <= mhup_pkg::DIV_RST[16*i +: 16];
        flow_q[i] <= mhup_pkg::FLOW_RST[i];
        role_q[i] <= mhup_pkg::ROLE_RST[2*i +: 2];
      end else if (CE && wr && sel_ctrl) begin
        div_q[i]  <= PWDATA[15:0];
        flow_q[i] <= PWDATA[mhup_pkg::CTRL_FLOW];
        role_q[i] <= PWDATA[mhup_pkg::CTRL_ROLE +: 2];
      end
    end

    // Error flags: set wins over clear
    always_ff @(posedge MCLK) begin
      if (SRST) begin
        ovr_q[i]  <= 1'b0;
        ferr_q[i] <= 1'b0;
      end else if (CE) begin
        ovr_q[i]  <= rx_ovr[i] | (ovr_q[i] & ~clr_ovr);
        ferr_q[i] <= rx_ferr[i] | (ferr_q[i] & ~clr_ferr);
      end
    end

    // receive on TXD, send on RXD
    mhup_uart_chan #(
      .DIV_W     (mhup_pkg::DIV_W),
      .DATA_BITS (mhup_pkg::DATA_BITS)
    ) u_chan (
      .clk          (MCLK),
      .srst         (SRST),
      .ce           (CE),
      .divisor      (div_q[i]),
      .flow_en      (flow_q[i]),
      .tx_data      (PWDATA[7:0]),
      .tx_valid     (tx_push),
      .tx_ready     (tx_ready[i]),
      .rx_data      (rx_data[i]),
      .rx_valid     (rx_valid[i]),
      .rx_take      (rx_pop),
      .rx_overrun   (rx_ovr[i]),
      .rx_frame_err (rx_ferr[i]),
      .serial_in    (LINK.host_txd[i]),
      .serial_out   (LINK.dev_rxd[i]),
      .peer_clear_n (LINK.rts_line_n[i]),
      .clear_n      (clear_n),
      .peer_req     (req[i])
    );

    if (i == 0) begin : g_cmd
      assign LINK.dev_cts_oe[i] = ~asleep_q;
      assign LINK.dev_cts_n[i]  = clear_n;
    end else begin : g_oth
      assign LINK.dev_cts_oe[i] = 1'b1;
      assign LINK.dev_cts_n[i]  = clear_n | asleep_q;
    end

    assign rd_port[i] =
      sel_ctrl ? {13'h0, role_q[i], flow_q[i], div_q[i]} :
      sel_rxd  ? {23'h0, rx_valid[i], rx_data[i]} :
      sel_stat ? {27'h0, req[i], ferr_q[i], ovr_q[i], rx_valid[i], tx_ready[i]} :
                 32'h0;
    assign PORT_ROLE[2*i +: 2] = role_q[i];
  end

  assign LINK.dev_rxd[mhup_pkg::SPARE]    = 1'b1;
  assign LINK.dev_cts_n[mhup_pkg::SPARE]  = 1'b1;
  assign LINK.dev_cts_oe[mhup_pkg::SPARE] = 1'b0;

  // ****************************************
  // Read data and answer
  // ****************************************
  logic [31:0] rdata_d;
  logic        err_d;
  always_comb begin
    rdata_d = 32'h0;
    err_d   = 1'b1;
    if (hit_pwr) begin
      rdata_d = {30'h0, wake_seen_q, asleep_q};
      err_d   = 1'b0;
    end else if (|hit_any) begin
      err_d = 1'b0;
      for (int i = 0; i < N; i++) begin
        rdata_d = rdata_d | rd_port[i];
      end
    end
  end

  // Captured in setup so a pop cannot change the word
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (CE && setup) begin
      prdata_q  <= PWRITE ? 32'h0 : rdata_d;
      pslverr_q <= err_d;
    end
  end
  assign PRDATA  = prdata_q;
  assign PSLVERR = pslverr_q & access;
  assign PREADY  = 1'b1;
endmodule : mhup_device
`default_nettype wire

// [pkg/mhup_pkg.sv]
// Purpose: shared constants for the host serial ports
// Assumes: 50 MHz MCLK
// Notes:   divisors are whole clocks per bit
package mhup_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_HZ    = 50_000_000;
  localparam int          BAUD_CMD  = 115200;
  localparam int          BAUD_DBG  = 921600;
  localparam int          BAUD_CON  = 115200;
  localparam int          DIV_W     = 16;
  localparam int          DATA_BITS = 8;
  localparam logic [15:0] DIV_CMD   = 16'(CLK_HZ / BAUD_CMD);
  localparam logic [15:0] DIV_DBG   = 16'(CLK_HZ / BAUD_DBG);
  localparam logic [15:0] DIV_CON   = 16'(CLK_HZ / BAUD_CON);
  // ****************************************
  // Ports and roles
  // ****************************************
  localparam int          NPORT        = 3;
  localparam int          NPIN         = 4;
  localparam int          SPARE        = 3;
  localparam logic [1:0]  ROLE_AT      = 2'h0;
  localparam logic [1:0]  ROLE_DEBUG   = 2'h1;
  localparam logic [1:0]  ROLE_CONSOLE = 2'h2;
  localparam logic [47:0] DIV_RST      = {DIV_CON, DIV_DBG, DIV_CMD};
  localparam logic [2:0]  FLOW_RST     = 3'h3;
  localparam logic [5:0]  ROLE_RST     = {ROLE_CONSOLE, ROLE_DEBUG, ROLE_AT};
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  STRIDE    = 8'h10;
  localparam logic [7:0]  OFS_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_TXD   = 8'h04;
  localparam logic [7:0]  OFS_RXD   = 8'h08;
  localparam logic [7:0]  OFS_STAT  = 8'h0c;
  localparam logic [7:0]  OFS_PWR   = 8'h30;
  localparam int          CTRL_FLOW = 16;
  localparam int          CTRL_ROLE = 17;
  localparam int          RXD_VALID = 8;
  localparam int          ST_TXRDY  = 0;
  localparam int          ST_RXVAL  = 1;
  localparam int          ST_OVR    = 2;
  localparam int          ST_FERR   = 3;
  localparam int          ST_REQ    = 4;
  localparam int          PWR_SLEEP = 0;
  localparam int          PWR_WAKE  = 1;
endpackage : mhup_pkg

// [pkg/mhup_link_if.sv]
// Purpose: serial link between modem ports and host
// Assumes: request and clear lines pulled high when undriven
// Notes:   index 3 is the spare port
`timescale 1ns/1ps
`default_nettype none
interface mhup_link_if;
  logic [3:0] host_txd;
  logic [3:0] dev_rxd;
  logic [3:0] host_rts_n;
  logic [3:0] host_rts_oe;
  logic [3:0] dev_cts_n;
  logic [3:0] dev_cts_oe;
  logic [3:0] rts_line_n;
  logic [3:0] cts_line_n;
  // Pull-ups on undriven handshake lines
  assign rts_line_n = host_rts_n | ~host_rts_oe;
  assign cts_line_n = dev_cts_n | ~dev_cts_oe;
  modport dev (input host_txd, rts_line_n, output dev_rxd, dev_cts_n, dev_cts_oe);
  modport host (input dev_rxd, cts_line_n, output host_txd, host_rts_n, host_rts_oe);
endinterface : mhup_link_if
`default_nettype wire

// [rtl/mhup_uart_chan.sv]
// Purpose: one serial channel, transmitter and receiver with handshake
// Assumes: divisor of at least 2
// Notes:   one-word receive holding register
`timescale 1ns/1ps
`default_nettype none
module mhup_uart_chan #(
  parameter int DIV_W     = 16,
  parameter int DATA_BITS = 8
) (
  // Clock and control
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 ce,
  input  wire logic [DIV_W-1:0]     divisor,
  input  wire logic                 flow_en,
  // Transmit side
  input  wire logic [DATA_BITS-1:0] tx_data,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  // Receive side
  output logic [DATA_BITS-1:0]      rx_data,
  output logic                      rx_valid,
  input  wire logic                 rx_take,
  output logic                      rx_overrun,
  output logic                      rx_frame_err,
  // Pins
  input  wire logic                 serial_in,
  output logic                      serial_out,
  input  wire logic                 peer_clear_n,
  output logic                      clear_n,
  output logic                      peer_req
);
  if (DATA_BITS < 5 || DATA_BITS > 9 || DIV_W < 4) begin : g_chk
    $error("mhup_uart_chan: unsupported width");
  end
  typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} mhup_ser_t;
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] s1_q, s2_q, s3_q, flt_q;
  wire  [1:0] agree = ~(s2_q ^ s3_q);
  wire  [1:0] flt_d = (agree & s2_q) | (~agree & flt_q);
  always_ff @(posedge clk) begin
    if (srst) begin
      {s1_q, s2_q, s3_q, flt_q} <= 8'hff;
    end else if (ce) begin
      s1_q  <= {peer_clear_n, serial_in};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= flt_d;
    end
  end
  assign peer_req = ~flt_q[1];
  wire rin = flt_q[0];
  // ****************************************
  // Transmitter
  // ****************************************
  mhup_ser_t            tst_q;
  logic [DIV_W-1:0]     tcnt_q, rcnt_q;
  logic [3:0]           tbit_q, rbit_q;
  logic [DATA_BITS-1:0] tsh_q, rsh_q;
  logic                 tout_q, rvalid_q, ovr_q, ferr_q;
  mhup_ser_t            rst_q;
  wire t_end   = tcnt_q == divisor - DIV_W'(1);
  wire t_last  = tbit_q == 4'(DATA_BITS - 1);
  assign tx_ready   = (tst_q == S_IDLE) & (~flow_en | peer_req);
  assign serial_out = tout_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      tst_q  <= S_IDLE;
      tout_q <= 1'b1;
      tcnt_q <= '0;
      tbit_q <= '0;
      tsh_q  <= '0;
    end else if (ce) begin
      tcnt_q <= (tst_q == S_IDLE || t_end) ? '0 : tcnt_q + DIV_W'(1);
      case (tst_q)
        S_IDLE: if (tx_valid && tx_ready) begin
          tsh_q  <= tx_data;
          tout_q <= 1'b0;
          tst_q  <= S_START;
        end
        S_START: if (t_end) begin
          tout_q <= tsh_q[0];
          tsh_q  <= tsh_q >> 1;
          tbit_q <= '0;
          tst_q  <= S_DATA;
        end
        S_DATA: if (t_end) begin
          tout_q <= t_last ? 1'b1 : tsh_q[0];
          tsh_q  <= tsh_q >> 1;
          tbit_q <= tbit_q + 4'h1;
          if (t_last) tst_q <= S_STOP;
        end
        default: if (t_end) tst_q <= S_IDLE;
      endcase
    end
  end
  // ****************************************
  // Receiver
  // ****************************************
  wire r_end  = rcnt_q == divisor - DIV_W'(1);
  wire r_half = rcnt_q == (divisor >> 1);
  wire r_last = rbit_q == 4'(DATA_BITS - 1);
  wire deliver = (rst_q == S_STOP) & r_end & rin;
  always_ff @(posedge clk) begin
    if (srst) begin
      rst_q    <= S_IDLE;
      rcnt_q   <= '0;
      rbit_q   <= '0;
      rsh_q    <= '0;
      rvalid_q <= 1'b0;
      rx_data  <= '0;
      ovr_q    <= 1'b0;
      ferr_q   <= 1'b0;
    end else if (ce) begin
      ovr_q  <= deliver & rvalid_q & ~rx_take;
      ferr_q <= (rst_q == S_STOP) & r_end & ~rin;
      // Set wins over the take in the same cycle
      rvalid_q <= deliver | (rvalid_q & ~rx_take);
      if (deliver && (!rvalid_q || rx_take)) rx_data <= rsh_q;
      rcnt_q <= (rst_q == S_IDLE || r_end || (rst_q == S_START && r_half)) ? '0
                : rcnt_q + DIV_W'(1);
      case (rst_q)
        S_IDLE: if (!rin) rst_q <= S_START;
        // Re-check mid start bit, drops glitches
        S_START: if (r_half) begin
          rst_q  <= rin ? S_IDLE : S_DATA;
          rbit_q <= '0;
        end
        S_DATA: if (r_end) begin
          rsh_q  <= {rin, rsh_q[DATA_BITS-1:1]};
          rbit_q <= rbit_q + 4'h1;
          if (r_last) rst_q <= S_STOP;
        end
        default: if (r_end) rst_q <= S_IDLE;
      endcase
    end
  end
  assign rx_valid     = rvalid_q;
  assign rx_overrun   = ovr_q;
  assign rx_frame_err = ferr_q;
  // Low means room for a character; always low with flow_en off
  assign clear_n = flow_en & rvalid_q;
endmodule : mhup_uart_chan
`default_nettype wire

// [rtl/mhup_host.sv]
// Purpose: host end of the serial ports
// Assumes: same divisors as the modem defaults
// Notes:   PARK releases request lines to their pull-ups
`timescale 1ns/1ps
`default_nettype none
module mhup_host (
  // Clock, reset, enable
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        CE,
  // Link
  mhup_link_if.host        LINK,
  // Transmit bytes, one lane per port
  input  wire logic [23:0] TX_DATA,
  input  wire logic [2:0]  TX_VALID,
  output logic [2:0]       TX_READY,
  // Receive bytes
  output logic [23:0]      RX_DATA,
  output logic [2:0]       RX_VALID,
  input  wire logic [2:0]  RX_TAKE,
  // Configuration
  input  wire logic [2:0]  FLOW_EN,
  input  wire logic        PARK
);
  for (genvar i = 0; i < mhup_pkg::NPORT; i++) begin : g_port
    wire clear_n;
    mhup_uart_chan #(
      .DIV_W     (mhup_pkg::DIV_W),
      .DATA_BITS (mhup_pkg::DATA_BITS)
    ) u_chan (
      .clk          (MCLK),
      .srst         (SRST),
      .ce           (CE),
      .divisor      (mhup_pkg::DIV_RST[16*i +: 16]),
      .flow_en      (FLOW_EN[i]),
      .tx_data      (TX_DATA[8*i +: 8]),
      .tx_valid     (TX_VALID[i]),
      .tx_ready     (TX_READY[i]),
      .rx_data      (RX_DATA[8*i +: 8]),
      .rx_valid     (RX_VALID[i]),
      .rx_take      (RX_TAKE[i]),
      .rx_overrun   (),
      .rx_frame_err (),
      .serial_in    (LINK.dev_rxd[i]),
      .serial_out   (LINK.host_txd[i]),
      .peer_clear_n (LINK.cts_line_n[i]),
      .clear_n      (clear_n),
      .peer_req     ()
    );
    assign LINK.host_rts_n[i]  = FLOW_EN[i] & clear_n;
    assign LINK.host_rts_oe[i] = ~PARK;
  end
  assign LINK.host_txd[mhup_pkg::SPARE]    = 1'b1;
  assign LINK.host_rts_n[mhup_pkg::SPARE]  = 1'b1;
  assign LINK.host_rts_oe[mhup_pkg::SPARE] = 1'b0;
endmodule : mhup_host
`default_nettype wire

// [tb/mhup_link_checker.sv]
// Purpose: timing checks on the serial link between both ends
// Assumes: CE held high, console port without handshake
// Notes:   frame counters watch all six data lines
`timescale 1ns/1ps
`default_nettype none
module mhup_link_checker (
  // Clock and reset
  input  wire logic       MCLK,
  input  wire logic       SRST,
  // Link
  input  wire logic [3:0] host_txd,
  input  wire logic [3:0] dev_rxd,
  input  wire logic [3:0] host_rts_n,
  input  wire logic [3:0] host_rts_oe,
  input  wire logic [3:0] dev_cts_oe,
  input  wire logic [3:0] rts_line_n,
  input  wire logic [3:0] cts_line_n,
  // Core status
  input  wire logic       ASLEEP
);
  // ****
  // Frame tracking
  // ****
  // Clocks per bit at 50 MHz, truncated
  localparam int D_SLOW = 434;
  localparam int D_FAST = 54;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  wire logic [5:0] ser = {host_txd[2:0], dev_rxd[2:0]};
  for (genvar i = 0; i < 6; i++) begin : g_fr
    localparam int D = (i % 3 == 1) ? D_FAST : D_SLOW;
    logic [12:0] k_q;
    logic        busy_q;
    // Ends one early so a back-to-back start is seen
    wire  logic  last = (k_q == 13'(10 * D - 2));
    always_ff @(posedge MCLK) begin
      if (SRST) begin
        busy_q <= 1'b0;
        k_q    <= 13'h0;
      end else begin
        busy_q <= busy_q ? !last : !ser[i];
        k_q    <= (busy_q && !last) ? k_q + 13'h1 : 13'h0;
      end
    end
    start_bit_low_a: assert property (busy_q && k_q <= 13'(D - 2) |-> !ser[i])
      else $error("start bit not low for a bit time");
    stop_bit_high_a: assert property (busy_q && k_q >= 13'(9 * D - 1) |-> ser[i])
      else $error("stop bit not high");
  end
  // ****
  // Handshake and sleep
  // ****
  // idle after reset
  reset_idle_a: assert property ($fell(SRST) |->
    dev_rxd[2:0] == 3'h7 && host_txd[2:0] == 3'h7)
    else $error("data lines not idle high after reset");
  clear_float_a: assert property (ASLEEP [*3] |-> !dev_cts_oe[0] && cts_line_n[0])
    else $error("command clear driven in sleep");
  clear_driven_a: assert property ((!ASLEEP) [*3] |-> dev_cts_oe[0])
    else $error("command clear undriven while awake");
  console_clear_a: assert property ((!ASLEEP) [*3] |-> !cts_line_n[2])
    else $error("console clear not asserted");
  console_req_a: assert property (host_rts_oe[2] |-> !host_rts_n[2])
    else $error("console request not held low");
  request_wake_a: assert property (ASLEEP && rts_line_n[1:0] != 2'h3 |-> ##[1:8] !ASLEEP)
    else $error("request line did not wake the modem");
  no_wake_a: assert property ((ASLEEP && rts_line_n[1:0] == 2'h3) [*4] |=> ASLEEP)
    else $error("modem woke without a request");
  sleep_c: cover property ($rose(ASLEEP));
  wake_c: cover property ($fell(ASLEEP));
  fast_frame_c: cover property ($fell(dev_rxd[1]));
endmodule : mhup_link_checker
`default_nettype wire

// [tb/modem_host_uart_ports_tb.sv]
// Purpose: bench joining modem and host ends of the serial ports
// Assumes: CE held high, console port without handshake
// Notes:   APB tasks wait for pready, watchdog bounds every wait
`timescale 1ns/1ps
`default_nettype none
module modem_host_uart_ports_tb;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        asleep;
  logic [5:0]  port_role;
  logic [23:0] tx_data = 24'h0;
  logic [2:0]  tx_valid = 3'h0;
  logic [2:0]  tx_ready;
  logic [23:0] rx_data;
  logic [2:0]  rx_valid;
  logic [2:0]  rx_take = 3'h0;
  logic        park = 1'b0;
  int          bad_count = 0;
  int          tests_run = 0;
  mhup_link_if link ();
  always #10 mclk = ~mclk;
  mhup_device mhup_device_inst (.MCLK(mclk), .SRST(srst), .CE(1'b1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINK(link.dev), .ASLEEP(asleep),
    .PORT_ROLE(port_role));
  mhup_host mhup_host_inst (.MCLK(mclk), .SRST(srst), .CE(1'b1), .LINK(link.host),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_DATA(rx_data),
    .RX_VALID(rx_valid), .RX_TAKE(rx_take), .FLOW_EN(3'h3), .PARK(park));
  mhup_link_checker mhup_link_checker_inst (.MCLK(mclk), .SRST(srst),
    .host_txd(link.host_txd), .dev_rxd(link.dev_rxd), .host_rts_n(link.host_rts_n),
    .host_rts_oe(link.host_rts_oe), .dev_cts_oe(link.dev_cts_oe),
    .rts_line_n(link.rts_line_n), .cts_line_n(link.cts_line_n), .ASLEEP(asleep));
  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, exp, q);
  endtask : rd
  // Clocks per bit: 50 MHz over 921600 or 115200, truncated
  function automatic int bit_clks(input int p);
    return (p == 1) ? 54 : 434;
  endfunction : bit_clks
  task automatic dev_send(input int p, input logic [7:0] b);
    logic [8:0] w;
    int         n;
    wr(8'(p * 16 + 4), {24'h0, b});
    for (n = 0; n < 50 && link.dev_rxd[p] !== 1'b0; n++)
      @(posedge mclk);
    repeat (bit_clks(p) / 2) @(posedge mclk);
    for (n = 0; n < 9; n++) begin
      repeat (bit_clks(p)) @(posedge mclk);
      w[n] = link.dev_rxd[p];
    end
    chk("wire frame", {23'h0, 1'b1, b}, {23'h0, w});
    for (n = 0; n < 5000 && rx_valid[p] !== 1'b1; n++)
      @(posedge mclk);
    chk("host rx valid", 32'h1, {31'h0, rx_valid[p]});
    chk("host rx byte", {24'h0, b}, {24'h0, rx_data[p*8 +: 8]});
    rx_take[p] <= 1'b1;
    @(posedge mclk);
    rx_take[p] <= 1'b0;
  endtask : dev_send
  task automatic host_send(input int p, input logic [7:0] b);
    logic [31:0] q;
    logic        e;
    int          n;
    @(posedge mclk);
    tx_data[p*8 +: 8] <= b;
    tx_valid[p]       <= 1'b1;
    @(posedge mclk);
    for (n = 0; n < 100 && tx_ready[p] !== 1'b1; n++)
      @(posedge mclk);
    tx_valid[p] <= 1'b0;
    q = 32'h0;
    for (n = 0; n < 2000 && q[1] !== 1'b1; n++)
      apb(1'b0, 8'(p * 16 + 12), 32'h0, q, e);
    // Host stop bit outlasts the modem's mid-stop sample
    repeat (bit_clks(p)) @(posedge mclk);
    chk("clear line", 32'(p < 2), 32'(link.cts_line_n[p]));
    chk("host tx ready", 32'(p == 2), 32'(tx_ready[p]));
    rd("dev rx byte", 8'(p * 16 + 8), {23'h0, 1'b1, b});
  endtask : host_send
  // ****
  // Sequence
  // ****
  initial begin
    logic [31:0] q;
    logic        e;
    int          p;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rd("ctrl cmd", 8'h00, 32'h0001_01b2);
    rd("ctrl dbg", 8'h10, 32'h0003_0036);
    rd("ctrl con", 8'h20, 32'h0004_01b2);
    chk("role reset", 32'h24, {26'h0, port_role});
    chk("spare idle", 32'h3, {30'h0, link.dev_rxd[3], link.host_txd[3]});
    rd("status cmd", 8'h0c, 32'h11);
    // Unmapped place is refused
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    wr(8'h10, 32'h0001_0036);
    @(posedge mclk);
    chk("role at", 32'h20, {26'h0, port_role});
    wr(8'h10, 32'h0003_0036);
    rd("ctrl dbg back", 8'h10, 32'h0003_0036);
    for (p = 0; p < 3; p++) begin
      dev_send(p, 8'ha5 ^ 8'(p));
      host_send(p, 8'h3c + 8'(p));
    end
    park <= 1'b1;
    repeat (8) @(posedge mclk);
    wr(8'h30, 32'h1);
    repeat (4) @(posedge mclk);
    chk("asleep", 32'h1, {31'h0, asleep});
    chk("clear floats", 32'h1, {31'h0, link.cts_line_n[0]});
    tx_data[23:16] <= 8'h77;
    tx_valid[2]    <= 1'b1;
    @(posedge mclk);
    tx_valid[2]    <= 1'b0;
    // Longer than one console frame
    repeat (5000) @(posedge mclk);
    chk("still asleep", 32'h1, {31'h0, asleep});
    rd("console kept", 8'h28, 32'h177);
    park <= 1'b0;
    for (p = 0; p < 20 && asleep !== 1'b0; p++)
      @(posedge mclk);
    chk("woken", 32'h0, {31'h0, asleep});
    rd("wake seen", 8'h30, 32'h2);
    wr(8'h30, 32'h2);
    rd("wake cleared", 8'h30, 32'h0);
    tally_and_finish();
  end
  // Run takes about 24000 cycles
  initial begin
    repeat (80000) @(posedge mclk);
    bad_count++;
    tally_and_finish();
  end
endmodule : modem_host_uart_ports_tb
`default_nettype wire
